// >>> pkg/status_report_regs.vh
// Purpose: constants for the standard event and measurement quality status block
// Assumes: included by bare name from the design files
// Notes: bit positions, valid masks, reset values and query answer widths
`ifndef STATUS_REPORT_REGS_VH
`define STATUS_REPORT_REGS_VH

// ----------------------------------------------------------------------------
// standard event flags, 8 bits
// ----------------------------------------------------------------------------
`define STD_WIDTH 8
`define STD_BIT_OP_COMPLETE 0
`define STD_BIT_QUERY_ERR 2
`define STD_BIT_DEVICE_ERR 3
`define STD_BIT_EXEC_ERR 4
`define STD_BIT_CMD_ERR 5
`define STD_BIT_POWER_ON 7
`define STD_VALID_MASK 8'hBD
`define STD_FLAGS_RESET 8'h80
`define STD_ENABLE_RESET 8'h00

// ----------------------------------------------------------------------------
// measurement quality status, 16 bits
// ----------------------------------------------------------------------------
`define QUAL_WIDTH 16
`define QUAL_BIT_POWER_SUM 3
`define QUAL_BIT_CAL_SUM 8
`define QUAL_BIT_SELF_TEST 9
`define QUAL_VALID_MASK 16'h0308
`define QUAL_ENABLE_MASK 16'h7FFF
`define QUAL_COND_RESET 16'h0000
`define QUAL_EVENT_RESET 16'h0000
`define QUAL_ENABLE_RESET 16'h0000

// ----------------------------------------------------------------------------
// status byte summary positions
// ----------------------------------------------------------------------------
`define STB_WIDTH 8
`define STB_BIT_QUAL_SUM 3
`define STB_BIT_STD_SUM 5
`define STB_RESET 8'h00

// ----------------------------------------------------------------------------
// query answer
// ----------------------------------------------------------------------------
`define RESP_WIDTH 16
`define RESP_RESET 16'h0000

`endif

// >>> src/op_complete_tracker.v
// Purpose: arms on an operation-complete request and fires when overlapped work drains
// Assumes: i_pending is a level from the command processor, high while any
//          overlapped command is still running
// Notes: o_done_pulse is a one-cycle registered pulse
`timescale 1ns/1ps
module op_complete_tracker (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_clk_en,
    input wire i_opc_request,
    input wire i_pending,
    input wire i_clear,
    output reg o_done_pulse
);

    // ------------------------------------------------------------------------
    // arm and fire
    // ------------------------------------------------------------------------
    reg armed_ff;
    reg nxt_armed;
    reg nxt_done;

    always @* begin
        nxt_armed = armed_ff;
        nxt_done = 1'b0;
        if (i_opc_request) begin
            nxt_armed = 1'b1;
        end else if (armed_ff && !i_pending) begin
            // all commands issued after the request are finished
            nxt_armed = 1'b0;
            nxt_done = 1'b1;
        end
        if (i_clear && !i_opc_request) begin
            nxt_armed = 1'b0;
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            armed_ff <= 1'b0;
            o_done_pulse <= 1'b0;
        end else if (i_clk_en) begin
            armed_ff <= nxt_armed;
            o_done_pulse <= nxt_done;
        end
    end

endmodule // op_complete_tracker

// >>> src/std_event_quality_status.v
// Purpose: standard event flags and measurement quality status with summaries
// Assumes: all command and event inputs come from the command processor on i_sys_clk;
//          command and event strobes are one-cycle pulses, qualifiers are levels
// Notes: reset stands for a power cycle; queries answer on o_resp_* one cycle later;
//        with several queries in one cycle the first listed answers, every clear still acts;
//        enable masks and quality conditions survive the clear-status command
//
// Functional notes
// - set event bit 0 when overlapped work after an operation-complete request ends
// - event bits 1 and 6 are unused and always read zero
// - set event bit 2 on every query error
// - set event bit 3 on every device-dependent error
// - set event bit 4 on every command execution error
// - set event bit 5 on every command syntax error
// - set event bit 7 at power-up to flag a power cycle
// - clear-status command and event status query clear the whole event register
// - event enable mask clears at power cycle and on writing zero
// - event summary is high when any flag is set with its enable bit
// - controller sets quality enable mask; enabled quality bits drive quality summary
// - set quality bit 3 on corrupt or questionable measurement data
// - clear quality bit 3 when a measurement completes free of those errors
// - set quality bit 8 when zeroing or calibration ends with its error
// - clear quality bit 8 when zeroing or calibration succeeds with no error
// - quality bit 9 follows the power-on self test failing or passing
// - quality group is 16 bits wide and bit 15 reads zero
// - event summary appears in status byte bit 5
// - quality summary appears in status byte bit 3, gated by its enable
`timescale 1ns/1ps
`include "status_report_regs.vh"
module std_event_quality_status (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_clk_en,
    // commands
    input wire i_clear_status,
    input wire i_opc_request,
    input wire i_overlapped_pending,
    input wire i_std_enable_wr,
    input wire [7:0] i_std_enable_data,
    input wire i_qual_enable_wr,
    input wire [15:0] i_qual_enable_data,
    // queries
    input wire i_std_flags_query,
    input wire i_std_enable_query,
    input wire i_qual_event_query,
    input wire i_qual_cond_query,
    input wire i_qual_enable_query,
    input wire i_status_byte_query,
    // error reports
    input wire i_query_error,
    input wire i_device_error,
    input wire i_exec_error,
    input wire i_syntax_error,
    // measurement quality
    input wire i_meas_done,
    input wire i_meas_data_corrupt,
    input wire i_meas_data_questionable,
    input wire i_cal_done,
    input wire i_cal_questionable,
    input wire i_cal_any_error,
    input wire i_self_test_done,
    input wire i_self_test_fail,
    // status views
    output reg [7:0] o_std_flags,
    output reg [7:0] o_std_enable,
    output reg [15:0] o_qual_cond,
    output reg [15:0] o_qual_event,
    output reg [15:0] o_qual_enable,
    output reg [7:0] o_status_byte,
    output reg o_resp_valid,
    output reg [15:0] o_resp_data
);

    // ------------------------------------------------------------------------
    // operation complete
    // ------------------------------------------------------------------------
    wire opc_done;

    op_complete_tracker u_opc (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_opc_request(i_opc_request),
        .i_pending(i_overlapped_pending),
        .i_clear(i_clear_status),
        .o_done_pulse(opc_done)
    );

    // ------------------------------------------------------------------------
    // clear strobes
    // ------------------------------------------------------------------------
    wire std_clear;
    wire qual_clear;

    // a query that reads an event register also empties it
    assign std_clear = i_clear_status | i_std_flags_query;
    assign qual_clear = i_clear_status | i_qual_event_query;

    // ------------------------------------------------------------------------
    // standard event flags
    // ------------------------------------------------------------------------
    reg [7:0] std_flags_ff;
    reg [7:0] std_enable_ff;
    reg [7:0] std_set;
    wire [7:0] nxt_std_flags;
    reg [7:0] nxt_std_enable;

    localparam [7:0] STD_VALID = `STD_VALID_MASK;
    genvar gs;

    always @* begin
        std_set = 8'h00;
        std_set[`STD_BIT_OP_COMPLETE] = opc_done;
        std_set[`STD_BIT_QUERY_ERR] = i_query_error;
        std_set[`STD_BIT_DEVICE_ERR] = i_device_error;
        std_set[`STD_BIT_EXEC_ERR] = i_exec_error;
        std_set[`STD_BIT_CMD_ERR] = i_syntax_error;
    end

    // per-bit latch: the whole register clears, a set in the same cycle survives
    generate
        for (gs = 0; gs < `STD_WIDTH; gs = gs + 1) begin : g_std_bit
            assign nxt_std_flags[gs] = STD_VALID[gs] &
                ((std_flags_ff[gs] & ~std_clear) | std_set[gs]);
        end
    endgenerate

    always @* begin
        nxt_std_enable = std_enable_ff;
        if (i_std_enable_wr) begin
            // a written zero clears the mask
            nxt_std_enable = i_std_enable_data;
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            std_flags_ff <= `STD_FLAGS_RESET;
            std_enable_ff <= `STD_ENABLE_RESET;
        end else if (i_clk_en) begin
            std_flags_ff <= nxt_std_flags;
            std_enable_ff <= nxt_std_enable;
        end
    end

    // ------------------------------------------------------------------------
    // quality condition
    // ------------------------------------------------------------------------
    reg [15:0] qual_cond_ff;
    reg [15:0] nxt_qual_cond;
    reg [15:0] qual_set;
    wire meas_bad;
    wire cal_bad;
    wire cal_good;

    assign meas_bad = i_meas_data_corrupt | i_meas_data_questionable;
    assign cal_bad = i_cal_done & i_cal_questionable;
    assign cal_good = i_cal_done & ~i_cal_any_error & ~i_cal_questionable;

    always @* begin
        nxt_qual_cond = qual_cond_ff;
        if (i_meas_done) begin
            nxt_qual_cond[`QUAL_BIT_POWER_SUM] = meas_bad;
        end
        if (cal_bad) begin
            nxt_qual_cond[`QUAL_BIT_CAL_SUM] = 1'b1;
        end else if (cal_good) begin
            nxt_qual_cond[`QUAL_BIT_CAL_SUM] = 1'b0;
        end
        if (i_self_test_done) begin
            nxt_qual_cond[`QUAL_BIT_SELF_TEST] = i_self_test_fail;
        end
        nxt_qual_cond = nxt_qual_cond & `QUAL_VALID_MASK;
    end

    // each set cause latches its bit into the event register
    always @* begin
        qual_set = 16'h0000;
        qual_set[`QUAL_BIT_POWER_SUM] = i_meas_done & meas_bad;
        qual_set[`QUAL_BIT_CAL_SUM] = cal_bad;
        qual_set[`QUAL_BIT_SELF_TEST] = i_self_test_done & i_self_test_fail;
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            qual_cond_ff <= `QUAL_COND_RESET;
        end else if (i_clk_en) begin
            qual_cond_ff <= nxt_qual_cond;
        end
    end

    // ------------------------------------------------------------------------
    // quality event and enable
    // ------------------------------------------------------------------------
    reg [15:0] qual_event_ff;
    reg [15:0] qual_enable_ff;
    wire [15:0] nxt_qual_event;
    reg [15:0] nxt_qual_enable;

    localparam [15:0] QUAL_VALID = `QUAL_VALID_MASK;
    genvar gq;

    // per-bit latch: a set in the same cycle as a clear survives
    generate
        for (gq = 0; gq < `QUAL_WIDTH; gq = gq + 1) begin : g_qual_bit
            assign nxt_qual_event[gq] = QUAL_VALID[gq] &
                ((qual_event_ff[gq] & ~qual_clear) | qual_set[gq]);
        end
    endgenerate

    always @* begin
        nxt_qual_enable = qual_enable_ff;
        if (i_qual_enable_wr) begin
            nxt_qual_enable = i_qual_enable_data & `QUAL_ENABLE_MASK;
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            qual_event_ff <= `QUAL_EVENT_RESET;
            qual_enable_ff <= `QUAL_ENABLE_RESET;
        end else if (i_clk_en) begin
            qual_event_ff <= nxt_qual_event;
            qual_enable_ff <= nxt_qual_enable;
        end
    end

    // ------------------------------------------------------------------------
    // summaries and status byte
    // ------------------------------------------------------------------------
    reg [7:0] nxt_status_byte;
    wire std_summary;
    wire qual_summary;

    // taken from next values so the byte moves with the registers it summarises
    assign std_summary = |(nxt_std_flags & nxt_std_enable);
    assign qual_summary = |(nxt_qual_event & nxt_qual_enable);

    always @* begin
        nxt_status_byte = 8'h00;
        nxt_status_byte[`STB_BIT_STD_SUM] = std_summary;
        nxt_status_byte[`STB_BIT_QUAL_SUM] = qual_summary;
    end

    // ------------------------------------------------------------------------
    // query select
    // ------------------------------------------------------------------------
    // answer select codes
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_STD_FLAGS = 3'h1;
    localparam [2:0] SEL_STD_ENABLE = 3'h2;
    localparam [2:0] SEL_QUAL_EVENT = 3'h3;
    localparam [2:0] SEL_QUAL_COND = 3'h4;
    localparam [2:0] SEL_QUAL_ENABLE = 3'h5;
    localparam [2:0] SEL_STATUS_BYTE = 3'h6;

    reg [2:0] query_sel;

    // one query per cycle expected; if several coincide the first listed answers
    always @* begin
        query_sel = SEL_NONE;
        if (i_std_flags_query) begin
            query_sel = SEL_STD_FLAGS;
        end else if (i_std_enable_query) begin
            query_sel = SEL_STD_ENABLE;
        end else if (i_qual_event_query) begin
            query_sel = SEL_QUAL_EVENT;
        end else if (i_qual_cond_query) begin
            query_sel = SEL_QUAL_COND;
        end else if (i_qual_enable_query) begin
            query_sel = SEL_QUAL_ENABLE;
        end else if (i_status_byte_query) begin
            query_sel = SEL_STATUS_BYTE;
        end
    end

    // ------------------------------------------------------------------------
    // query answers
    // ------------------------------------------------------------------------
    reg nxt_resp_valid;
    reg [15:0] nxt_resp_data;
    wire any_query;

    assign any_query = i_std_flags_query | i_std_enable_query | i_qual_event_query |
        i_qual_cond_query | i_qual_enable_query | i_status_byte_query;

    // the answer shows the register as it stood before the query edge
    always @* begin
        nxt_resp_valid = any_query;
        case (query_sel)
            SEL_STD_FLAGS: begin
                nxt_resp_data = {8'h00, std_flags_ff};
            end
            SEL_STD_ENABLE: begin
                nxt_resp_data = {8'h00, std_enable_ff};
            end
            SEL_QUAL_EVENT: begin
                nxt_resp_data = qual_event_ff;
            end
            SEL_QUAL_COND: begin
                nxt_resp_data = qual_cond_ff;
            end
            SEL_QUAL_ENABLE: begin
                nxt_resp_data = qual_enable_ff;
            end
            SEL_STATUS_BYTE: begin
                nxt_resp_data = {8'h00, o_status_byte};
            end
            default: begin
                nxt_resp_data = `RESP_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_std_flags <= `STD_FLAGS_RESET;
            o_std_enable <= `STD_ENABLE_RESET;
            o_qual_cond <= `QUAL_COND_RESET;
            o_qual_event <= `QUAL_EVENT_RESET;
            o_qual_enable <= `QUAL_ENABLE_RESET;
            o_status_byte <= `STB_RESET;
            o_resp_valid <= 1'b0;
            o_resp_data <= `RESP_RESET;
        end else if (i_clk_en) begin
            o_std_flags <= nxt_std_flags;
            o_std_enable <= nxt_std_enable;
            o_qual_cond <= nxt_qual_cond;
            o_qual_event <= nxt_qual_event;
            o_qual_enable <= nxt_qual_enable;
            o_status_byte <= nxt_status_byte;
            o_resp_valid <= nxt_resp_valid;
            o_resp_data <= nxt_resp_data;
        end
    end

endmodule // std_event_quality_status

// >>> dv/std_event_quality_status_properties.sv
// Purpose: port-level assertions for the status block
// Assumes: one clock domain, reset asynchronous and active low
// Notes: attached to the top module by the bind at the foot
`timescale 1ns/1ps
`include "status_report_regs.vh"
module std_event_quality_status_properties (
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire i_clk_en,
    input wire i_std_flags_query,
    input wire i_query_error,
    input wire i_device_error,
    input wire i_exec_error,
    input wire i_syntax_error,
    input wire i_meas_done,
    input wire i_meas_data_corrupt,
    input wire i_meas_data_questionable,
    input wire i_self_test_done,
    input wire i_self_test_fail,
    input wire [7:0] o_std_flags,
    input wire [7:0] o_std_enable,
    input wire [15:0] o_qual_cond,
    input wire [15:0] o_qual_event,
    input wire [15:0] o_qual_enable,
    input wire [7:0] o_status_byte,
    input wire o_resp_valid,
    input wire [15:0] o_resp_data
);
    wire [3:0] err = {i_syntax_error, i_exec_error, i_device_error, i_query_error};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    property p_flags_read;
        i_clk_en && i_std_flags_query |=> o_resp_valid && o_resp_data == {8'h00, $past(o_std_flags)};
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flags answer wrong");
    property p_unused_std; o_std_flags[1] == 1'b0 && o_std_flags[6] == 1'b0; endproperty
    a_unused_std: assert property (p_unused_std) else $error("unused flag set");
    property p_err_set; i_clk_en |=> (o_std_flags[5:2] & $past(err)) == $past(err); endproperty
    a_err_set: assert property (p_err_set) else $error("error flag missed");
    property p_std_sum; o_status_byte[5] == |(o_std_flags & o_std_enable); endproperty
    a_std_sum: assert property (p_std_sum) else $error("event summary wrong");
    property p_qual_sum; o_status_byte[3] == |(o_qual_event & o_qual_enable); endproperty
    a_qual_sum: assert property (p_qual_sum) else $error("quality summary wrong");
    property p_qual_unused;
        ((o_qual_cond | o_qual_event) & ~`QUAL_VALID_MASK) == 16'h0000 && !o_qual_enable[15];
    endproperty
    a_qual_unused: assert property (p_qual_unused) else $error("unused quality bit");
    property p_meas;
        i_clk_en && i_meas_done |=>
            o_qual_cond[3] == $past(i_meas_data_corrupt || i_meas_data_questionable);
    endproperty
    a_meas: assert property (p_meas) else $error("power summary wrong");
    property p_self; i_clk_en && i_self_test_done |=> o_qual_cond[9] == $past(i_self_test_fail);
    endproperty
    a_self: assert property (p_self) else $error("self test bit wrong");
    c_read: cover property (i_std_flags_query && o_std_flags != 8'h00);
    c_meas: cover property (i_meas_done && i_meas_data_corrupt);
    c_self: cover property (i_self_test_done && i_self_test_fail);
endmodule // std_event_quality_status_properties
bind std_event_quality_status std_event_quality_status_properties
    std_event_quality_status_properties_inst (.*);

// >>> dv/status_controller_model.sv
// Purpose: remote controller issuing status commands and queries
// Assumes: strobe bits 0..9 map to the command and query inputs
// Notes: data is scrambled once a command is over
`timescale 1ns/1ps
module status_controller_model (
    input wire i_sys_clk,
    input wire i_resp_valid,
    input wire [15:0] i_resp_data,
    output reg [9:0] o_strobe,
    output reg [15:0] o_data
);
    initial begin
        o_strobe = 10'h000;
        o_data = 16'h0000;
    end
    // mask values go out as weighted binary words
    task send(input [9:0] s, input [15:0] d);
        begin
            @(posedge i_sys_clk);
            #1;
            o_strobe = s;
            o_data = d;
            @(posedge i_sys_clk);
            #1;
            o_strobe = 10'h000;
            o_data = ~d;
        end
    endtask
    // the answer stands in the cycle after the taken edge
    task ask(input integer idx, output [15:0] r);
        begin
            send(10'h001 << idx, 16'h0000);
            r = i_resp_valid ? i_resp_data : 16'hxxxx;
        end
    endtask
endmodule // status_controller_model

// >>> dv/std_event_quality_status_tb_top.sv
// Purpose: self-checking bench for the status block
// Assumes: controller model issues commands, bench drives event reports
// Notes: random masks and error patterns from a fixed xorshift seed
`timescale 1ns/1ps
module std_event_quality_status_tb_top;
    reg i_sys_clk = 1'b0;
    reg i_reset_n = 1'b0;
    reg i_clk_en = 1'b1;
    reg i_overlapped_pending = 1'b0;
    reg [11:0] ev = 12'h000;
    reg [31:0] seed = 32'h37AA;
    reg [15:0] r;
    reg [7:0] ex;
    reg [7:0] en;
    integer i, n;
    integer num_errors = 0;
    integer total_checks = 0;
    wire [9:0] cmd;
    wire [15:0] cmd_data;
    wire i_clear_status, i_opc_request, i_std_enable_wr, i_qual_enable_wr, i_std_flags_query;
    wire i_std_enable_query, i_qual_event_query, i_qual_cond_query, i_qual_enable_query;
    wire i_status_byte_query, i_query_error, i_device_error, i_exec_error, i_syntax_error;
    wire i_meas_done, i_meas_data_corrupt, i_meas_data_questionable, i_cal_done;
    wire i_cal_questionable, i_cal_any_error, i_self_test_done, i_self_test_fail;
    wire [7:0] i_std_enable_data = cmd_data[7:0];
    wire [15:0] i_qual_enable_data = cmd_data;
    wire [7:0] o_std_flags, o_std_enable, o_status_byte;
    wire [15:0] o_qual_cond, o_qual_event, o_qual_enable, o_resp_data;
    wire o_resp_valid;
    assign {i_status_byte_query, i_qual_enable_query, i_qual_cond_query, i_qual_event_query,
        i_std_enable_query, i_std_flags_query, i_qual_enable_wr, i_std_enable_wr,
        i_opc_request, i_clear_status} = cmd;
    assign {i_self_test_fail, i_self_test_done, i_cal_any_error, i_cal_questionable,
        i_cal_done, i_meas_data_questionable, i_meas_data_corrupt, i_meas_done,
        i_syntax_error, i_exec_error, i_device_error, i_query_error} = ev;
    std_event_quality_status std_event_quality_status_inst (.*);
    status_controller_model status_controller_model_inst (.i_sys_clk(i_sys_clk),
        .i_resp_valid(o_resp_valid), .i_resp_data(o_resp_data), .o_strobe(cmd),
        .o_data(cmd_data));
    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function std_sum(input [7:0] f, input [7:0] e);
        std_sum = |(f & e);
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    task pulse(input [11:0] v);
        begin
            @(posedge i_sys_clk);
            #1 ev = v;
            @(posedge i_sys_clk);
            #1 ev = 12'h000;
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        status_controller_model_inst.ask(4, r);
        chk(r, 16'h0080);
        status_controller_model_inst.ask(4, r);
        chk(r, 16'h0000);
        ex = 8'h00;
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            en = seed[7:0];
            status_controller_model_inst.send(10'h004, {8'h00, en});
            pulse({8'h00, seed[11:8]});
            ex = ex | {2'b00, seed[11:8], 2'b00};
            chk(o_std_flags, ex);
            chk(o_status_byte[5], std_sum(ex, en));
            if (seed[12]) begin
                status_controller_model_inst.send(10'h001, 16'h0000);
                chk(o_std_flags, 8'h00);
                ex = 8'h00;
            end else if (seed[13]) begin
                status_controller_model_inst.ask(4, r);
                chk(r, {8'h00, ex});
                chk(o_std_flags, 8'h00);
                ex = 8'h00;
            end
        end
        status_controller_model_inst.send(10'h004, 16'h0000);
        status_controller_model_inst.ask(5, r);
        chk(r, 16'h0000);
        status_controller_model_inst.send(10'h001, 16'h0000);
        i_overlapped_pending = 1'b1;
        status_controller_model_inst.send(10'h002, 16'h0000);
        repeat (3) @(posedge i_sys_clk);
        #1 chk(o_std_flags[0], 1'b0);
        i_overlapped_pending = 1'b0;
        n = 0;
        while (o_std_flags[0] !== 1'b1 && n < 8) begin
            @(posedge i_sys_clk);
            #1 n = n + 1;
        end
        chk(o_std_flags, 8'h01);
        status_controller_model_inst.send(10'h008, 16'hFFFF);
        status_controller_model_inst.ask(8, r);
        chk(r, 16'h7FFF);
        pulse(12'h030);
        chk(o_qual_cond, 16'h0008);
        chk(o_status_byte[3], 1'b1);
        pulse(12'h010);
        chk(o_qual_cond, 16'h0000);
        status_controller_model_inst.ask(6, r);
        chk(r, 16'h0008);
        chk(o_status_byte[3], 1'b0);
        pulse(12'h050);
        pulse(12'h180);
        chk(o_qual_cond, 16'h0108);
        pulse(12'h280);
        chk(o_qual_cond, 16'h0108);
        pulse(12'h080);
        chk(o_qual_cond, 16'h0008);
        pulse(12'hC00);
        chk(o_qual_cond, 16'h0208);
        pulse(12'h400);
        chk(o_qual_cond, 16'h0008);
        chk(o_qual_event, 16'h0308);
        status_controller_model_inst.ask(7, r);
        chk(r, 16'h0008);
        status_controller_model_inst.ask(9, r);
        chk(r, 16'h0008);
        i_clk_en = 1'b0;
        pulse(12'h004);
        chk(o_std_flags, 8'h01);
        i_clk_en = 1'b1;
        #1 i_reset_n = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        chk(o_std_flags, 8'h80);
        chk({o_std_enable, o_qual_enable[7:0]}, 16'h0000);
        results;
    end
endmodule // std_event_quality_status_tb_top
